// [spi_master_end.sv]
// master end: shift clock generator, word sequencer and per-slave selects
// assumes steps are pulses and the slaves are running before the first step
`timescale 1ns/1ns

// Overview of operation
// [R1] words carry one to sixteen bits
// [R2] shift clock from core clock over prescaler
// [R3] polarity sets the idle clock level
// [R4] polarity zero: rising edge, modes zero, one
// [R5] polarity one: falling edge, modes two, three
// [R6] words per step set per slave
// [R7] one active-low select output per slave
// [R8] slave drives return only while selected
// [R9] slave flags valid and presents received word
// [R10] unread word overwritten sets slave overrun
// [R11] master does not wait for slaves; they must be running first
// [R12] shift one edge, sample the other
// [R13] one slave per step, cycling through all
// [R14] overrun on step while busy, valid after all
// [R15] words go most significant bit first
// [R16] idle: selects high, clock at idle
module spi_master_end
  import spi_link_pkg::*;
(
  // system
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  // configuration
  input  wire spi_mode_t                   mode,
  input  wire logic [BITS_W-1:0]           bits_per_word,
  input  wire logic [DIV_W-1:0]            clk_half_div,
  input  wire logic [NUM_SLAVES*CNT_W-1:0] words_per_slave,
  // execution step
  input  wire logic                        step,
  output logic                             busy,
  output logic                             valid,
  output logic                             overrun,
  // transmit word vector
  input  wire logic                        tx_wr,
  input  wire logic [ADDR_W-1:0]           tx_addr,
  input  wire logic [WORD_W-1:0]           tx_wdata,
  // receive word vector
  input  wire logic [ADDR_W-1:0]           rx_addr,
  output logic      [WORD_W-1:0]           rx_rdata,
  // link
  spi_link_if.master                       link
);

  typedef enum logic [2:0] {
    st_idle, st_load, st_lead, st_shift, st_done
  } mst_state_t;

  mst_state_t            state_reg, state_next;
  logic [PRE_W-1:0]      pre_reg, pre_next;
  logic [DIV_W-1:0]      half_reg, half_next;
  logic                  act_reg, act_next;
  logic                  mosi_reg, mosi_next;
  logic [WORD_W-1:0]     tx_sh_reg, tx_sh_next;
  logic [WORD_W-1:0]     rx_sh_reg, rx_sh_next;
  logic [BITS_W-1:0]     bit_reg, bit_next;
  logic [CNT_W-1:0]      word_reg, word_next;
  logic [SLV_W-1:0]      slave_reg, slave_next;
  logic [NUM_SLAVES-1:0] cs_n_reg, cs_n_next;
  logic                  valid_reg, valid_next;
  logic                  ovr_reg, ovr_next;
  logic [WORD_W-1:0]     rx_out_reg;
  logic                  tick, half_done, pha, rx_we;
  logic [BITS_W-1:0]     nb;
  logic [ADDR_W-1:0]     waddr;
  logic [WORD_W-1:0]     rx_wd;

  // word vectors, slave after slave
  logic [WORD_W-1:0] tx_mem [MEM_DEPTH];
  logic [WORD_W-1:0] rx_mem [MEM_DEPTH];

  assign pha   = mode_pha(mode);
  assign nb    = eff_bits(bits_per_word);                          // R1
  assign waddr = word_base(words_per_slave, int'(slave_reg)) +
                 ADDR_W'(word_reg);

  // peripheral tick, then half periods counted in ticks
  assign tick      = (pre_reg == PRE_LAST);                        // R2
  assign half_done = tick && (half_reg == clk_half_div);           // R2

  // clock level is the active phase folded onto the idle level
  assign link.shift_clock     = act_reg ^ mode_pol(mode);          // R3 R16
  assign link.master_out_line = mosi_reg;
  assign link.slave_select_n  = cs_n_reg;                          // R7 R16

  assign busy     = (state_reg != st_idle);
  assign valid    = valid_reg;
  assign overrun  = ovr_reg;
  assign rx_rdata = rx_out_reg;

  // sequencer and shift engine
  always_comb begin
    state_next = state_reg;
    pre_next   = tick ? '0 : pre_reg + PRE_W'(1);
    half_next  = half_reg;
    act_next   = act_reg;
    mosi_next  = mosi_reg;
    tx_sh_next = tx_sh_reg;
    rx_sh_next = rx_sh_reg;
    bit_next   = bit_reg;
    word_next  = word_reg;
    slave_next = slave_reg;
    cs_n_next  = cs_n_reg;
    valid_next = valid_reg;
    ovr_next   = ovr_reg;
    rx_we      = 1'b0;
    rx_wd      = rx_sh_reg;
    // a step that finds the last one unfinished is an overrun
    if (step && state_reg != st_idle) ovr_next = 1'b1;             // R14
    if (state_reg != st_idle && tick) begin
      half_next = half_done ? '0 : half_reg + DIV_W'(1);
    end
    case (state_reg)
      st_idle: begin
        if (step) begin
          ovr_next   = 1'b0;
          valid_next = 1'b0;
          word_next  = '0;
          if (words_of(words_per_slave, int'(slave_reg)) == '0) begin
            // nothing for this slave: its turn passes
            slave_next = slave_reg + SLV_W'(1);                    // R13
            if (slave_reg == SLV_W'(NUM_SLAVES - 1)) begin
              valid_next = 1'b1;
            end
          end else begin
            // only the slave of this step is selected
            cs_n_next  = ~(NUM_SLAVES'(1) << slave_reg);           // R13 R7
            state_next = st_load;
          end
        end
      end
      st_load: begin
        tx_sh_next = align_msb(tx_mem[waddr], nb);                 // R15
        bit_next   = '0;
        half_next  = '0;
        if (pha) begin
          // delayed variant: msb out two half periods early
          mosi_next  = tx_sh_next[WORD_W-1];                       // R12
          tx_sh_next = tx_sh_next << 1;
        end
        state_next = st_lead;
      end
      st_lead: begin
        if (half_done) state_next = st_shift;
      end
      st_shift: begin
        if (half_done) begin
          act_next = ~act_reg;
          if (!act_reg) begin
            // leading edge
            if (pha) rx_sh_next = {rx_sh_reg[WORD_W-2:0],
                                   link.master_in_line};           // R4 R5
            else begin
              mosi_next  = tx_sh_reg[WORD_W-1];                    // R12
              tx_sh_next = tx_sh_reg << 1;
            end
          end else begin
            // trailing edge
            if (!pha) rx_sh_next = {rx_sh_reg[WORD_W-2:0],
                                    link.master_in_line};          // R12
            if (bit_reg == nb - BITS_W'(1)) begin
              rx_we     = 1'b1;
              rx_wd     = mask_low(rx_sh_next, nb);                // R1 R15
              word_next = word_reg + CNT_W'(1);
              if (word_next == words_of(words_per_slave,
                                        int'(slave_reg))) begin    // R6
                // select held one more cycle: slaves see this edge late
                state_next = st_done;
                slave_next = slave_reg + SLV_W'(1);                // R13
                if (slave_reg == SLV_W'(NUM_SLAVES - 1)) begin
                  valid_next = 1'b1;                               // R14
                end
              end else begin
                state_next = st_load;
              end
            end else begin
              bit_next = bit_reg + BITS_W'(1);
              if (pha) begin
                mosi_next  = tx_sh_reg[WORD_W-1];
                tx_sh_next = tx_sh_reg << 1;
              end
            end
          end
        end
      end
      st_done: begin
        cs_n_next  = CS_ALL_IDLE;                                  // R16
        state_next = st_idle;
      end
      default: state_next = st_idle;
    endcase
  end

  // registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= st_idle;
      pre_reg   <= '0;
      half_reg  <= '0;
      act_reg   <= 1'b0;
      mosi_reg  <= 1'b0;
      tx_sh_reg <= WORD_ZERO;
      rx_sh_reg <= WORD_ZERO;
      bit_reg   <= '0;
      word_reg  <= '0;
      slave_reg <= '0;
      cs_n_reg  <= CS_ALL_IDLE;
      valid_reg <= 1'b0;
      ovr_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      pre_reg   <= pre_next;
      half_reg  <= half_next;
      act_reg   <= act_next;
      mosi_reg  <= mosi_next;
      tx_sh_reg <= tx_sh_next;
      rx_sh_reg <= rx_sh_next;
      bit_reg   <= bit_next;
      word_reg  <= word_next;
      slave_reg <= slave_next;
      cs_n_reg  <= cs_n_next;
      valid_reg <= valid_next;
      ovr_reg   <= ovr_next;
    end
  end

  // word stores; contents are not reset, read data is
  always_ff @(posedge clock) begin
    if (tx_wr) tx_mem[tx_addr] <= tx_wdata;
    if (rx_we) rx_mem[waddr] <= rx_wd;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) rx_out_reg <= WORD_ZERO;
    else rx_out_reg <= rx_mem[rx_addr];
  end

endmodule

// [spi_link_pkg.sv]
// shared constants, mode coding and helpers for both ends of the serial link
// assumes one core clock; the shift clock is produced by the master end
package spi_link_pkg;

  // word geometry
  localparam int WORD_W = 16;
  localparam int BITS_W = 5;
  localparam logic [BITS_W-1:0] BITS_MIN = 5'h01;
  localparam logic [BITS_W-1:0] BITS_MAX = 5'h10;

  // slave count and per-step word storage
  localparam int NUM_SLAVES = 2;
  localparam int SLV_W      = 1;
  localparam int MAX_WORDS  = 8;
  localparam int CNT_W      = 4;
  localparam int MEM_DEPTH  = NUM_SLAVES * MAX_WORDS;
  localparam int ADDR_W     = 4;

  // clocking: core clock / PERIPH_DIV gives the peripheral tick
  localparam int PERIPH_DIV = 4;
  localparam int PRE_W      = 3;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PERIPH_DIV - 1);
  localparam int DIV_W      = 8;

  // reset values
  localparam logic [NUM_SLAVES-1:0] CS_ALL_IDLE = '1;
  localparam logic [WORD_W-1:0]     WORD_ZERO   = 16'h0000;

  // mode code order gives codes zero to three
  typedef enum logic [1:0] {
    rise_delayed_mode,
    rise_undelayed_mode,
    fall_delayed_mode,
    fall_undelayed_mode
  } spi_mode_t;

  // idle level of the shift clock
  function automatic logic mode_pol(input spi_mode_t m);
    logic [1:0] v;
    v = m;
    return v[1];
  endfunction

  // delayed variant: data out two half periods before first edge
  function automatic logic mode_pha(input spi_mode_t m);
    logic [1:0] v;
    v = m;
    return ~v[0];
  endfunction

  // clamp the word length into 1..16
  function automatic logic [BITS_W-1:0] eff_bits(input logic [BITS_W-1:0] b);
    if (b < BITS_MIN) return BITS_MIN;
    else if (b > BITS_MAX) return BITS_MAX;
    return b;
  endfunction

  // words for one slave, clamped to storage
  function automatic logic [CNT_W-1:0] words_of(
    input logic [NUM_SLAVES*CNT_W-1:0] cfg, input int s);
    logic [CNT_W-1:0] c;
    c = cfg[s*CNT_W +: CNT_W];
    if (c > CNT_W'(MAX_WORDS)) c = CNT_W'(MAX_WORDS);
    return c;
  endfunction

  // first word of a slave in the concatenated word vector
  function automatic logic [ADDR_W-1:0] word_base(
    input logic [NUM_SLAVES*CNT_W-1:0] cfg, input int s);
    int acc;
    acc = 0;
    for (int i = 0; i < NUM_SLAVES; i++) begin
      if (i < s) acc = acc + int'(words_of(cfg, i));
    end
    return ADDR_W'(acc);
  endfunction

  // left-align so the first bit out is the word's msb
  function automatic logic [WORD_W-1:0] align_msb(
    input logic [WORD_W-1:0] d, input logic [BITS_W-1:0] nb);
    return d << (BITS_W'(WORD_W) - nb);
  endfunction

  // keep only the low nb bits of an assembled word
  function automatic logic [WORD_W-1:0] mask_low(
    input logic [WORD_W-1:0] d, input logic [BITS_W-1:0] nb);
    logic [WORD_W:0] m;
    m = (17'h00001 << nb) - 17'h00001;
    return d & m[WORD_W-1:0];
  endfunction

endpackage

// [spi_link_if.sv]
// wires of the serial link between one master end and the slave ends
// assumes each slave drives only its own bit of the return lines
`timescale 1ns/1ns
interface spi_link_if;
  import spi_link_pkg::*;

  // master driven
  logic                  shift_clock;
  logic                  master_out_line;
  logic [NUM_SLAVES-1:0] slave_select_n;
  // slave driven, one bit per slave
  wire  [NUM_SLAVES-1:0] miso_out;
  wire  [NUM_SLAVES-1:0] miso_oe;
  // resolved return line; nothing driving reads low
  wire                   master_in_line;

  assign master_in_line = |(miso_out & miso_oe);

  modport master (
    output shift_clock,
    output master_out_line,
    output slave_select_n,
    input  master_in_line
  );

  modport slave (
    input  shift_clock,
    input  master_out_line,
    input  slave_select_n,
    output miso_out,
    output miso_oe
  );
endinterface

// [spi_slave_end.sv]
// slave end: follows master clock and its own active-low select
// assumes link pins are synchronous to clock and half periods >= 2 cycles
`timescale 1ns/1ns
module spi_slave_end
  import spi_link_pkg::*;
#(
  parameter int SLAVE_INDEX = 0
) (
  // system
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // configuration
  input  wire spi_mode_t         mode,
  input  wire logic [BITS_W-1:0] bits_per_word,
  // user data
  input  wire logic [WORD_W-1:0] tx_data,
  input  wire logic              rx_read,
  output logic      [WORD_W-1:0] rx_data,
  output logic                   valid,
  output logic                   overrun,
  // link
  spi_link_if.slave              link
);

  logic [WORD_W-1:0] tx_sh_reg, tx_sh_next;
  logic [WORD_W-1:0] rx_sh_reg, rx_sh_next;
  logic [WORD_W-1:0] rx_reg, rx_next;
  logic [BITS_W-1:0] bit_reg, bit_next;
  logic              out_reg, out_next;
  logic              sck_reg, sel_reg;
  logic              unread_reg, unread_next;
  logic              ovr_reg, ovr_next;
  logic              sel, act, act_prev, lead, trail, pha, load;
  logic [BITS_W-1:0] nb;

  // edges seen relative to the idle level
  assign sel      = ~link.slave_select_n[SLAVE_INDEX];
  assign pha      = mode_pha(mode);
  assign nb       = eff_bits(bits_per_word);
  assign act      = link.shift_clock ^ mode_pol(mode);            // R3
  assign act_prev = sck_reg ^ mode_pol(mode);
  assign lead     = sel & act & ~act_prev;                        // R4 R5
  assign trail    = sel & ~act & act_prev;                        // R12

  // return line only while selected
  assign link.miso_out[SLAVE_INDEX] = out_reg;
  assign link.miso_oe[SLAVE_INDEX]  = sel;                         // R8

  assign rx_data = rx_reg;
  assign valid   = unread_reg;
  assign overrun = ovr_reg;

  // shift engine and receive flags
  always_comb begin
    tx_sh_next  = tx_sh_reg;
    rx_sh_next  = rx_sh_reg;
    rx_next     = rx_reg;
    bit_next    = bit_reg;
    out_next    = out_reg;
    unread_next = unread_reg;
    ovr_next    = ovr_reg;
    load        = 1'b0;
    // a read clears, a new word in the same cycle wins
    if (rx_read) begin
      unread_next = 1'b0;
      ovr_next    = 1'b0;
    end
    if (!sel) begin
      // deselect mid-word drops the partial word
      bit_next = '0;                                               // R11
    end else if (!sel_reg) begin
      load = 1'b1;
    end else if (lead) begin
      if (pha) rx_sh_next = {rx_sh_reg[WORD_W-2:0], link.master_out_line};
      else begin
        out_next   = tx_sh_reg[WORD_W-1];                          // R15
        tx_sh_next = tx_sh_reg << 1;
      end
    end else if (trail) begin
      if (!pha) rx_sh_next = {rx_sh_reg[WORD_W-2:0], link.master_out_line};
      if (bit_reg == nb - BITS_W'(1)) begin
        rx_next     = mask_low(rx_sh_next, nb);                    // R1 R9
        unread_next = 1'b1;                                        // R9
        if (unread_reg && !rx_read) ovr_next = 1'b1;               // R10
        bit_next    = '0;
        load        = 1'b1;
      end else begin
        bit_next = bit_reg + BITS_W'(1);
        if (pha) begin
          out_next   = tx_sh_reg[WORD_W-1];
          tx_sh_next = tx_sh_reg << 1;
        end
      end
    end
    // next word: delayed variant presents its msb at once
    if (load) begin
      tx_sh_next = align_msb(tx_data, nb);
      if (pha) begin
        out_next   = tx_sh_next[WORD_W-1];                         // R12
        tx_sh_next = tx_sh_next << 1;
      end
    end
  end

  // registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_sh_reg  <= WORD_ZERO;
      rx_sh_reg  <= WORD_ZERO;
      rx_reg     <= WORD_ZERO;
      bit_reg    <= '0;
      out_reg    <= 1'b0;
      sck_reg    <= 1'b0;
      sel_reg    <= 1'b0;
      unread_reg <= 1'b0;
      ovr_reg    <= 1'b0;
    end else begin
      tx_sh_reg  <= tx_sh_next;
      rx_sh_reg  <= rx_sh_next;
      rx_reg     <= rx_next;
      bit_reg    <= bit_next;
      out_reg    <= out_next;
      sck_reg    <= link.shift_clock;
      sel_reg    <= sel;
      unread_reg <= unread_next;
      ovr_reg    <= ovr_next;
    end
  end

endmodule

// [spi_link_props.sv]
// assertions on the serial link between the master end and slave ends
// assumes the bench instantiates it beside the one link it builds
`timescale 1ns/1ns
module spi_link_props
  import spi_link_pkg::*;
(
  // system
  input wire logic                  clock,
  input wire logic                  sys_rst,
  // configuration
  input wire spi_mode_t             mode,
  input wire logic [BITS_W-1:0]     bits_per_word,
  // link
  input wire logic                  shift_clock,
  input wire logic                  master_out_line,
  input wire logic [NUM_SLAVES-1:0] slave_select_n,
  input wire logic [NUM_SLAVES-1:0] miso_out,
  input wire logic [NUM_SLAVES-1:0] miso_oe,
  input wire logic                  master_in_line
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  logic       clk_prev_reg;
  spi_mode_t  mode_q1_reg;
  spi_mode_t  mode_q2_reg;
  logic [9:0] edge_cnt_reg;
  logic [9:0] edge_cnt_next;
  wire        mode_calm = (mode == mode_q1_reg) && (mode == mode_q2_reg);

  // clock edges inside one selection; cleared while all are idle
  always_comb begin
    edge_cnt_next = edge_cnt_reg;
    if (&slave_select_n) edge_cnt_next = 10'h000;
    else if (shift_clock != clk_prev_reg)
      edge_cnt_next = edge_cnt_reg + 10'h001;
  end

  // delays; mode history lets the idle level settle after a change
  always_ff @(posedge clock) begin
    clk_prev_reg <= shift_clock;
    mode_q1_reg  <= mode;
    mode_q2_reg  <= mode_q1_reg;
    edge_cnt_reg <= sys_rst ? 10'h000 : edge_cnt_next;
  end

  one_select_a: assert property ($onehot0(~slave_select_n))
    else $error("more than one slave selected");
  idle_clock_a: assert property (&slave_select_n && mode_calm
    |-> shift_clock == mode_pol(mode))
    else $error("shift clock not at idle level");
  oe_select_a: assert property ((miso_oe & slave_select_n) == '0)
    else $error("slave drives return line while unselected");
  quiet_line_a: assert property (&slave_select_n |-> !master_in_line)
    else $error("return line active with no slave selected");
  clk_only_sel_a: assert property ($changed(shift_clock) && mode_calm
    |-> !(&slave_select_n))
    else $error("shift clock moved outside a selection");
  sel_start_a: assert property ($fell(slave_select_n[0])
    || $fell(slave_select_n[1])
    |-> shift_clock == mode_pol(mode) ##1 shift_clock == mode_pol(mode))
    else $error("clock left idle too soon after select");
  half_period_a: assert property ($changed(shift_clock) && mode_calm
    |=> $stable(shift_clock) [*3])
    else $error("half period shorter than four cycles");
  word_edges_a: assert property ($rose(&slave_select_n)
    |-> edge_cnt_reg != 10'h000
    && (edge_cnt_reg % {4'h0, bits_per_word, 1'b0}) == 10'h000)
    else $error("edge count not whole words");
endmodule

// [tb.sv]
// self-checking bench: one master end and two slave ends on one link
// assumes two slaves and word counts within the package limits
`timescale 1ns/1ns
module tb;
  import spi_link_pkg::*;
  // stimulus and observed signals
  logic                        clock;
  logic                        sys_rst;
  spi_mode_t                   mode;
  logic [BITS_W-1:0]           bits_per_word;
  logic [DIV_W-1:0]            clk_half_div;
  logic [NUM_SLAVES*CNT_W-1:0] words_per_slave;
  logic                        step;
  wire                         busy;
  wire                         m_valid;
  wire                         m_overrun;
  logic                        tx_wr;
  logic [ADDR_W-1:0]           tx_addr;
  logic [WORD_W-1:0]           tx_wdata;
  logic [ADDR_W-1:0]           rx_addr;
  wire  [WORD_W-1:0]           rx_rdata;
  logic [WORD_W-1:0]           s_tx [NUM_SLAVES];
  logic [NUM_SLAVES-1:0]       s_read;
  wire  [WORD_W-1:0]           s_rx [NUM_SLAVES];
  wire  [NUM_SLAVES-1:0]       s_valid;
  wire  [NUM_SLAVES-1:0]       s_ovr;
  int                          error_cnt;
  int                          n_compared;
  int                          cycles;

  spi_link_if lnk ();

  spi_master_end spi_master_end_inst (
    .clock(clock), .sys_rst(sys_rst), .mode(mode),
    .bits_per_word(bits_per_word), .clk_half_div(clk_half_div),
    .words_per_slave(words_per_slave), .step(step), .busy(busy),
    .valid(m_valid), .overrun(m_overrun), .tx_wr(tx_wr),
    .tx_addr(tx_addr), .tx_wdata(tx_wdata), .rx_addr(rx_addr),
    .rx_rdata(rx_rdata), .link(lnk.master));

  for (genvar i = 0; i < NUM_SLAVES; i++) begin : g_slv
    spi_slave_end #(.SLAVE_INDEX(i)) spi_slave_end_inst (
      .clock(clock), .sys_rst(sys_rst), .mode(mode),
      .bits_per_word(bits_per_word), .tx_data(s_tx[i]),
      .rx_read(s_read[i]), .rx_data(s_rx[i]), .valid(s_valid[i]),
      .overrun(s_ovr[i]), .link(lnk.slave));
  end

  spi_link_props spi_link_props_inst (
    .clock(clock), .sys_rst(sys_rst), .mode(mode),
    .bits_per_word(bits_per_word), .shift_clock(lnk.shift_clock),
    .master_out_line(lnk.master_out_line),
    .slave_select_n(lnk.slave_select_n), .miso_out(lnk.miso_out),
    .miso_oe(lnk.miso_oe), .master_in_line(lnk.master_in_line));

  // 250 MHz core clock
  always #2 clock = ~clock;

  task automatic report_and_stop;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard, far above the under two thousand cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk_word(input logic [WORD_W-1:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // low nb bits of a word, worked out independently
  function automatic logic [WORD_W-1:0] low(input logic [WORD_W-1:0] d,
                                            input int nb);
    logic [WORD_W:0] m;
    m = (17'h00001 << nb) - 17'h00001;
    return d & m[WORD_W-1:0];
  endfunction

  function automatic logic [WORD_W-1:0] mword(input int k, m);
    return 16'hA5C3 ^ WORD_W'(k * 4369 + m);
  endfunction

  task automatic wr_tx(input int a, input logic [WORD_W-1:0] d);
    @(negedge clock);
    tx_wr = 1'b1;
    tx_addr = ADDR_W'(a);
    tx_wdata = d;
    @(negedge clock);
    tx_wr = 1'b0;
  endtask

  task automatic chk_rx(input int a, input logic [WORD_W-1:0] exp);
    @(negedge clock);
    rx_addr = ADDR_W'(a);
    @(negedge clock);
    chk_word(rx_rdata, exp);
  endtask

  task automatic pulse_step;
    @(negedge clock);
    step = 1'b1;
    @(negedge clock);
    step = 1'b0;
  endtask

  // bounded wait for the master to go idle, then let slaves settle
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    repeat (4) @(negedge clock);
  endtask

  // every mode with a different word length, two steps each
  task automatic modes_and_lengths;
    int nbt [4] = '{16, 1, 8, 5};
    for (int m = 0; m < 4; m++) begin
      @(negedge clock);
      mode = spi_mode_t'(m);
      bits_per_word = BITS_W'(nbt[m]);
      s_tx[0] = 16'h5A3C ^ WORD_W'(m);
      s_tx[1] = 16'hC3E1 ^ WORD_W'(m * 16);
      for (int k = 0; k < 3; k++) wr_tx(k, mword(k, m));
      repeat (4) @(negedge clock);
      chk_bit(lnk.shift_clock, 1'(m > 1));
      pulse_step();
      wait_idle();
      chk_rx(0, low(s_tx[0], nbt[m]));
      chk_rx(1, low(s_tx[0], nbt[m]));
      chk_word(s_rx[0], low(mword(1, m), nbt[m]));
      chk_bit(s_valid[0], 1'b1);
      chk_bit(s_ovr[0], 1'b1);
      chk_bit(s_valid[1], 1'b0);
      chk_bit(m_valid, 1'b0);
      pulse_step();
      wait_idle();
      chk_rx(2, low(s_tx[1], nbt[m]));
      chk_word(s_rx[1], low(mword(2, m), nbt[m]));
      chk_bit(s_ovr[1], 1'b0);
      chk_bit(m_valid, 1'b1);
      s_read = 2'h3;
      @(negedge clock);
      s_read = 2'h0;
      @(negedge clock);
      chk_bit(|{s_valid, s_ovr}, 1'b0);
    end
  endtask

  // a step that lands while busy flags overrun and is not served
  task automatic early_step;
    @(negedge clock);
    clk_half_div = 8'h02;
    pulse_step();
    repeat (3) @(negedge clock);
    pulse_step();
    chk_bit(m_overrun, 1'b1);
    chk_bit(busy, 1'b1);
    wait_idle();
    chk_bit(m_valid, 1'b0);
    pulse_step();
    wait_idle();
    chk_bit(m_overrun, 1'b0);
    chk_bit(m_valid, 1'b1);
    chk_word(s_rx[1], low(mword(2, 3), 5));
  endtask

  // a slave with no words loses its turn without a transfer
  task automatic skip_slave;
    @(negedge clock);
    words_per_slave = 8'h10;
    pulse_step();
    chk_bit(busy, 1'b0);
    chk_bit(m_valid, 1'b0);
    pulse_step();
    wait_idle();
    chk_rx(0, low(s_tx[1], 5));
    chk_word(s_rx[1], low(mword(0, 3), 5));
    chk_bit(m_valid, 1'b1);
  endtask

  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    mode = rise_delayed_mode;
    bits_per_word = 5'h10;
    clk_half_div = 8'h00;
    words_per_slave = 8'h12;
    step = 1'b0;
    tx_wr = 1'b0;
    tx_addr = 4'h0;
    tx_wdata = 16'h0000;
    rx_addr = 4'h0;
    s_tx[0] = 16'h0000;
    s_tx[1] = 16'h0000;
    s_read = 2'h0;
    error_cnt = 0;
    n_compared = 0;
    cycles = 0;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    // slaves out of reset well before the first step
    repeat (4) @(negedge clock);
    chk_bit(&lnk.slave_select_n, 1'b1);
    modes_and_lengths();
    early_step();
    skip_slave();
    report_and_stop();
  end
endmodule
